// File: verification/gate_driver_fault_regs_tb.sv
// Self-checking bench for the fault register block
`timescale 1ns/1ps
`default_nettype none
module gate_driver_fault_regs_tb;
  logic clk = 1'b0, rst = 1'b1, clamp_enable = 1'b1, conversion_done = 1'b0;
  logic self_test_done = 1'b0;
  logic [9:0] primary_fault_event = 10'h000, secondary_fault_event = 10'h000;
  logic [9:0] conversion_result = 10'h000, self_test_vector = 10'h000, st_vec = 10'h000;
  logic [5:0] pins = 6'h00;
  logic [23:0] rx;
  wire sclk, cs_n, sdi, sdo, sdo_oe, pwm_enable, miller_clamp_active;
  wire fault_output_pin_n, conversion_request, self_test_request;
  wire [2:0] conversion_source_select;
  int num_errors = 0;
  int checks = 0;
  int st_cnt = 0;
  gate_driver_fault_regs i_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .primary_fault_event(primary_fault_event),
    .secondary_fault_event(secondary_fault_event), .clamp_enable(clamp_enable),
    .pwm_enable(pwm_enable), .gate_low_force(),
    .miller_clamp_active(miller_clamp_active), .fault_output_pin_n(fault_output_pin_n),
    .isolation_failsafe_pin(pins[5]), .pwm_in(pins[4]), .alternate_drive_input(pins[3]),
    .failsafe_state_pin(pins[2]), .failsafe_enable_pin(pins[1]), .gate_voltage_pin(pins[0]),
    .conversion_request(conversion_request),
    .conversion_source_select(conversion_source_select),
    .conversion_done(conversion_done), .conversion_result(conversion_result),
    .self_test_request(self_test_request), .self_test_done(self_test_done),
    .self_test_vector(self_test_vector));
  host_spi_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Converter and self-test engine answer one clock after the request; result encodes the source
  always @(posedge clk) begin
    conversion_done <= conversion_request;
    conversion_result <= {7'h53, conversion_source_select};
    self_test_done <= self_test_request;
    self_test_vector <= st_vec;
    st_cnt <= st_cnt + int'(self_test_request);
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [9:0] d);
    i_host.send(1'b0, a, d, rx);
  endtask
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    i_host.send(1'b1, a, d, rx);
  endtask
  task automatic answer(input logic [4:0] a, input logic [9:0] d);
    check("answer", rx, {1'b0, a, d, i_host.crc8({1'b0, a, d})});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One event cycle, then stop and latch are judged and the status is read away
  task automatic fault_case(input bit sec, input int b, input bit lat, input bit stop);
    logic [9:0] ev;
    ev = 10'h001 << b;
    secondary_fault_event <= sec ? ev : 10'h000;
    primary_fault_event <= sec ? 10'h000 : ev;
    @(posedge clk);
    secondary_fault_event <= 10'h000;
    primary_fault_event <= 10'h000;
    repeat (2) @(posedge clk);
    #1;
    check("pwm_enable", pwm_enable, !stop);
    check("clamp", miller_clamp_active, stop && clamp_enable);
    check("fault pin", fault_output_pin_n, !lat);
    rd(sec ? 5'h0c : 5'h0a, 10'h000);
    rd(5'h0e, 10'h000);
    check("latched", rx[8 + b], lat);
    check("pwm_enable", pwm_enable, 1'b1);
  endtask
  task automatic t_reset();
    check("fault pin", fault_output_pin_n, 1'b1);
    check("sdo enable", sdo_oe, 1'b0);
    rd(5'h0b, 10'h000);
    rd(5'h0d, 10'h000);
    answer(5'h0b, 10'h338);
    rd(5'h1f, 10'h000);
    answer(5'h0d, 10'h0ee);
    rd(5'h0e, 10'h000);
    answer(5'h1f, 10'h000);
    $display("reset done");
  endtask
  task automatic t_pins();
    for (int k = 0; k < 2; k++) begin
      pins <= k ? 6'h15 : 6'h2a;
      repeat (8) @(posedge clk);
      rd(5'h0e, 10'h000);
      rd(5'h1f, 10'h000);
      answer(5'h0e, {3'h0, pins[5:1], 1'b1, pins[0]});
    end
    $display("pins done");
  endtask
  task automatic t_faults();
    fault_case(0, 7, 0, 0);
    fault_case(0, 9, 1, 1);
    clamp_enable <= 1'b0;
    fault_case(0, 8, 1, 1);
    clamp_enable <= 1'b1;
    fault_case(0, 5, 1, 1);
    fault_case(0, 3, 1, 1);
    fault_case(0, 4, 1, 0);
    wr(5'h0b, 10'h340);
    fault_case(0, 5, 0, 0);
    fault_case(0, 4, 0, 0);
    fault_case(1, 7, 1, 0);
    fault_case(1, 6, 1, 0);
    fault_case(1, 5, 1, 1);
    fault_case(1, 4, 0, 0);
    fault_case(1, 3, 1, 1);
    fault_case(1, 2, 1, 1);
    fault_case(1, 0, 0, 0);
    fault_case(1, 8, 1, 1);
    wr(5'h0d, 10'h013);
    fault_case(1, 4, 1, 1);
    fault_case(1, 1, 1, 1);
    fault_case(1, 0, 1, 1);
    fault_case(1, 7, 0, 0);
    fault_case(1, 3, 0, 0);
    wr(5'h0d, 10'h0ee);
    $display("faults done");
  endtask
  task automatic t_frame_error();
    i_host.xfer({1'b1, 5'h0d, 10'h000, i_host.crc8({1'b1, 5'h0d, 10'h000}) ^ 8'hff}, rx);
    rd(5'h0d, 10'h000);
    rd(5'h0c, 10'h000);
    answer(5'h0d, 10'h0ee);
    rd(5'h0e, 10'h000);
    check("host error", rx[14], 1'b1);
    check("pwm_enable", pwm_enable, 1'b1);
    $display("frame error done");
  endtask
  task automatic t_convert();
    for (int s = 0; s < 4; s++) begin
      rd(5'h10, s[9:0]);
      rd(5'h10, s[9:0]);
      rd(5'h0e, 10'h000);
      answer(5'h10, {7'h53, s[2:0]});
    end
    $display("convert done");
  endtask
  task automatic t_self_test();
    rd(5'h11, 10'h001);
    check("ignored request", st_cnt, 0);
    for (int k = 0; k < 2; k++) begin
      st_vec <= k ? 10'h15a : 10'h2a5;
      rd(5'h11, 10'h000);
      rd(5'h11, 10'h000);
      rd(5'h0e, 10'h000);
      answer(5'h11, st_vec);
      check("pwm_enable", pwm_enable, 1'b0);
      rd(5'h0c, 10'h000);
      rd(5'h0e, 10'h000);
    end
    check("request count", st_cnt, 4);
    $display("self test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_pins();
    t_faults();
    t_frame_error();
    t_convert();
    t_self_test();
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire

// File: verification/gate_fault_monitor.sv
// Port assertions for the fault register block
`timescale 1ns/1ps
`default_nettype none
module gate_fault_monitor (
  input wire clk,
  input wire rst,
  input wire [9:0] primary_fault_event,
  input wire [9:0] secondary_fault_event,
  input wire clamp_enable,
  input wire pwm_enable,
  input wire gate_low_force,
  input wire miller_clamp_active,
  input wire fault_output_pin_n,
  input wire conversion_request,
  input wire [2:0] conversion_source_select,
  input wire self_test_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence stop_then_pin;
    ##1 !pwm_enable ##1 !fault_output_pin_n;
  endsequence
  sequence keeps_running;
    ##1 pwm_enable;
  endsequence
  gate_low_a: assert property (gate_low_force == !pwm_enable)
    else $error("gate low force wrong");
  clamp_out_a: assert property (miller_clamp_active == (gate_low_force && clamp_enable))
    else $error("clamp output wrong");
  unmaskable_stop_a: assert property (secondary_fault_event[9:8] != 2'b00 |-> stop_then_pin)
    else $error("unmaskable fault did not stop");
  host_err_a: assert property (pwm_enable && secondary_fault_event == 10'h040
      && primary_fault_event == 10'h000 |-> keeps_running)
    else $error("host interface error stopped switching");
  warn_only_a: assert property (pwm_enable && primary_fault_event == 10'h010
      && secondary_fault_event == 10'h000 |-> keeps_running)
    else $error("warning stopped switching");
  conv_pulse_a: assert property (conversion_request |=> !conversion_request)
    else $error("conversion request too long");
  test_pulse_a: assert property (self_test_request |=> !self_test_request)
    else $error("self test request too long");
  select_hold_a: assert property ($changed(conversion_source_select) |-> conversion_request)
    else $error("source select moved without request");
endmodule
bind gate_driver_fault_regs gate_fault_monitor i_mon (.clk(clk), .rst(rst),
  .primary_fault_event(primary_fault_event), .secondary_fault_event(secondary_fault_event),
  .clamp_enable(clamp_enable), .pwm_enable(pwm_enable), .gate_low_force(gate_low_force),
  .miller_clamp_active(miller_clamp_active), .fault_output_pin_n(fault_output_pin_n),
  .conversion_request(conversion_request),
  .conversion_source_select(conversion_source_select),
  .self_test_request(self_test_request));
`default_nettype wire

// File: verification/host_spi_model.sv
// Host controller model: SPI master sending frames and gathering answers
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  input wire clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // check byte over rw, address, data
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // msb first; answer bit read late as the block needs sync time
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      sdi <= tx[i];
      half();
      sclk <= 1'b1;
      half();
      rx[i] = sdo;
      sclk <= 1'b0;
    end
    half();
    cs_n <= 1'b1;
    sdi <= ~tx[0];
    repeat (10) @(posedge clk);
  endtask
  task automatic send(input logic rw, input logic [4:0] a, input logic [9:0] d,
                      output logic [23:0] rx);
    xfer({rw, a, d, crc8({rw, a, d})}, rx);
  endtask
endmodule
`default_nettype wire

// File: verilog/frame_crc.v
// Parallel CRC-8 over the 16 header and data bits of a frame
`timescale 1ns/1ps
`include "gate_fault_defines.vh"
`default_nettype none
module frame_crc #(
  parameter [7:0] POLY = `CRC_POLY,
  parameter [7:0] INIT = `CRC_INIT
) (
  input wire [15:0] payload,
  output reg [7:0] crc
);
  integer k;
  reg fb;
  always @* begin
    crc = INIT;
    fb = 1'b0;
    for (k = 15; k >= 0; k = k - 1) begin
      fb = crc[7] ^ payload[k];
      crc = {crc[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
    end
  end
endmodule
`default_nettype wire

// File: verilog/gate_driver_fault_regs.v
// Fault mask, status, pin level and request registers behind the SPI port
`timescale 1ns/1ps
`include "gate_fault_defines.vh"
`default_nettype none
module gate_driver_fault_regs (
  input wire clk,
  input wire rst,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  output reg sdo,
  output wire sdo_oe,
  input wire [9:0] primary_fault_event,
  input wire [9:0] secondary_fault_event,
  input wire clamp_enable,
  output wire pwm_enable,
  output wire gate_low_force,
  output wire miller_clamp_active,
  output reg fault_output_pin_n,
  input wire isolation_failsafe_pin,
  input wire pwm_in,
  input wire alternate_drive_input,
  input wire failsafe_state_pin,
  input wire failsafe_enable_pin,
  input wire gate_voltage_pin,
  output reg conversion_request,
  output reg [2:0] conversion_source_select,
  input wire conversion_done,
  input wire [9:0] conversion_result,
  output reg self_test_request,
  input wire self_test_done,
  input wire [9:0] self_test_vector
);
  localparam [4:0] LAST_BIT = 5'd23;

  // Synchronised pin levels
  wire [9:0] pin_raw;
  wire [9:0] pin_lvl;
  wire sclk_q;
  wire cs_n_q;
  wire sdi_q;
  wire [6:0] pins_q;

  reg sclk_d_r;
  reg cs_n_d_r;
  reg [23:0] shift_r;
  reg [4:0] bit_cnt_r;
  reg full_r;
  reg [4:0] last_addr_r;
  reg last_rw_r;

  reg [9:0] mask1_r;
  reg [9:0] mask2_r;
  reg [9:0] status1_r;
  reg [9:0] fault_status_secondary_r;
  reg [9:0] result_r;
  reg [9:0] vector_r;
  reg [6:0] pin_status_r;

  wire sclk_rise;
  wire sclk_fall;
  wire frame_start;
  wire frame_end;
  wire rx_rw;
  wire [4:0] rx_addr;
  wire [9:0] rx_data;
  wire [7:0] rx_crc_calc;
  wire rx_ok;
  wire frame_err;
  wire [9:0] emask1;
  wire [9:0] emask2;
  wire [9:0] set1;
  wire [9:0] set2;
  wire [9:0] resp_data;
  wire [7:0] tx_crc;
  wire clr1;
  wire clr2;
  wire stop;

  // Select enters inverted so the reset value is its idle level
  assign pin_raw = {sclk, ~cs_n, sdi, isolation_failsafe_pin, pwm_in,
                    alternate_drive_input, failsafe_state_pin,
                    failsafe_enable_pin, 1'b0, gate_voltage_pin};

  pin_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin(pin_raw),
    .level(pin_lvl)
  );

  assign sclk_q = pin_lvl[9];
  assign cs_n_q = ~pin_lvl[8];
  assign sdi_q = pin_lvl[7];
  // The fault pin level is the one this block drives
  assign pins_q = {pin_lvl[6:2], fault_output_pin_n, pin_lvl[0]};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_q;
      cs_n_d_r <= cs_n_q;
    end
  end

  assign sclk_rise = sclk_q & ~sclk_d_r & ~cs_n_q;
  assign sclk_fall = ~sclk_q & sclk_d_r & ~cs_n_q;
  assign frame_start = ~cs_n_q & cs_n_d_r;
  assign frame_end = cs_n_q & ~cs_n_d_r;

  assign rx_rw = shift_r[`FRAME_RW_BIT];
  assign rx_addr = shift_r[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign rx_data = shift_r[`FRAME_DATA_HI:`FRAME_DATA_LO];

  frame_crc u_rx_crc (
    .payload(shift_r[23:8]),
    .crc(rx_crc_calc)
  );

  // whole frames, checked CRC
  // Daisy chains clock multiples of 24; the last 24 bits are ours
  assign rx_ok = full_r && (bit_cnt_r == 5'd0) &&
                 (rx_crc_calc == shift_r[`FRAME_CRC_HI:0]);
  assign frame_err = frame_end & ~rx_ok;

  // Response data for the previous command
  function [9:0] read_mux;
    input [4:0] a;
    begin
      if (a == `ADDR_STATUS_PRIMARY) begin
        read_mux = status1_r;
      end else if (a == `ADDR_MASK_PRIMARY) begin
        read_mux = mask1_r;
      end else if (a == `ADDR_STATUS_SECONDARY) begin
        read_mux = fault_status_secondary_r;
      end else if (a == `ADDR_MASK_SECONDARY) begin
        read_mux = mask2_r;
      end else if (a == `ADDR_PIN_LEVEL) begin
        read_mux = {3'b000, pin_status_r};
      end else if (a == `ADDR_CONV_REQ) begin
        // 10-bit code of 5 V / 1024
        read_mux = result_r;
      end else if (a == `ADDR_SELF_TEST) begin
        read_mux = vector_r;
      end else begin
        read_mux = 10'h000;
      end
    end
  endfunction

  assign resp_data = read_mux(last_addr_r);

  frame_crc u_tx_crc (
    .payload({last_rw_r, last_addr_r, resp_data}),
    .crc(tx_crc)
  );

  // MSB first shift, out on fall, in on rise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= 24'h000000;
      bit_cnt_r <= 5'd0;
      full_r <= 1'b0;
      sdo <= 1'b0;
    end else if (frame_start) begin
      shift_r <= {last_rw_r, last_addr_r, resp_data, tx_crc};
      bit_cnt_r <= 5'd0;
      full_r <= 1'b0;
      sdo <= last_rw_r;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[22:0], sdi_q};
      if (bit_cnt_r == LAST_BIT) begin
        bit_cnt_r <= 5'd0;
        full_r <= 1'b1;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'd1;
      end
    end else if (sclk_fall) begin
      sdo <= shift_r[23];
    end
  end

  assign sdo_oe = ~cs_n_q;

  // Remember the command answered in the next frame
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_addr_r <= 5'd0;
      last_rw_r <= 1'b0;
    end else if (frame_end && rx_ok) begin
      last_addr_r <= rx_addr;
      last_rw_r <= rx_rw;
    end
  end

  // Mask registers; reserved bits stay zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mask1_r <= `MASK_PRIMARY_RST;
      mask2_r <= `MASK_SECONDARY_RST;
    end else if (frame_end && rx_ok && rx_rw) begin
      if (rx_addr == `ADDR_MASK_PRIMARY) begin
        mask1_r <= rx_data & `MASK_PRIMARY_BITS;
      end else if (rx_addr == `ADDR_MASK_SECONDARY) begin
        mask2_r <= rx_data & `MASK_SECONDARY_BITS;
      end
    end
  end

  // masked faults never reach the latch
  assign emask1 = mask1_r & `MASK_PRIMARY_BITS;
  // rail faults gated by mask data bits 1 and 0
  // Self-test and logic supply faults have no mask
  assign emask2 = {2'b11, mask2_r[7:2],
                   mask2_r[`FAULT_MASK_SECONDARY_REF_RANGE], mask2_r[`FAULT_MASK_SECONDARY_NEG_RAIL]};

  // masked shutdown neither latches nor stops switching
  // warning latches when unmasked, never stops
  assign set1 = primary_fault_event & emask1;

  // frame errors feed the host interface bit
  // self-test failure sets its status bit
  assign set2 = (secondary_fault_event |
                 ({10{frame_err}} & (10'h001 << `ST2_HOST_IF)) |
                 ({10{self_test_done & (|self_test_vector)}} &
                  (10'h001 << `ST2_SELF_TEST))) & emask2;

  // Statuses clear once loaded into a response
  assign clr1 = frame_start && (last_addr_r == `ADDR_STATUS_PRIMARY);
  assign clr2 = frame_start && (last_addr_r == `ADDR_STATUS_SECONDARY);

  // Set wins over a read clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status1_r <= 10'h000;
      fault_status_secondary_r <= 10'h000;
    end else begin
      status1_r <= (clr1 ? 10'h000 : status1_r) | set1;
      fault_status_secondary_r <= (clr2 ? 10'h000 : fault_status_secondary_r) | set2;
    end
  end

  // gate voltage fault in stop set
  assign stop = |(status1_r & `PRIMARY_STOP_BITS) |
                |(fault_status_secondary_r & `SECONDARY_STOP_BITS);

  assign pwm_enable = ~stop;
  assign gate_low_force = stop;
  assign miller_clamp_active = stop & clamp_enable;

  // Fault pin low while any fault is latched
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_output_pin_n <= 1'b1;
    end else begin
      fault_output_pin_n <= ~(|set1 | |set2 |
                              |((clr1 ? 10'h000 : status1_r)) |
                              |((clr2 ? 10'h000 : fault_status_secondary_r)));
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_status_r <= 7'h00;
    end else begin
      pin_status_r <= pins_q;
    end
  end

  // requests are never gated by fault masks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_request <= 1'b0;
      conversion_source_select <= 3'd0;
    end else begin
      conversion_request <= 1'b0;
      if (frame_end && rx_ok && !rx_rw &&
          rx_addr == `ADDR_CONV_REQ) begin
        conversion_request <= 1'b1;
        conversion_source_select <= rx_data[2:0];
      end
    end
  end

  // temperature code kept even when masked
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= 10'h000;
    end else if (conversion_done) begin
      result_r <= conversion_result;
    end
  end

  // only the all-zero data command starts a test
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      self_test_request <= 1'b0;
    end else begin
      self_test_request <= frame_end && rx_ok && !rx_rw &&
                           (rx_addr == `ADDR_SELF_TEST) &&
                           (rx_data == 10'h000);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_r <= 10'h000;
    end else if (self_test_done) begin
      vector_r <= self_test_vector;
    end
  end
endmodule
`default_nettype wire

// File: verilog/gate_fault_defines.vh
// Register map, field positions, reset values and frame constants
`ifndef GATE_FAULT_DEFINES_VH
`define GATE_FAULT_DEFINES_VH

// Frame layout
`define FRAME_BITS 24
`define FRAME_RW_BIT 23
`define FRAME_ADDR_HI 22
`define FRAME_ADDR_LO 18
`define FRAME_DATA_HI 17
`define FRAME_DATA_LO 8
`define FRAME_CRC_HI 7
`define CRC_POLY 8'h07
`define CRC_INIT 8'hff

// Register addresses
`define ADDR_STATUS_PRIMARY 5'h0a
`define ADDR_MASK_PRIMARY 5'h0b
`define ADDR_STATUS_SECONDARY 5'h0c
`define ADDR_MASK_SECONDARY 5'h0d
`define ADDR_PIN_LEVEL 5'h0e
`define ADDR_CONV_REQ 5'h10
`define ADDR_SELF_TEST 5'h11

// Reset values and writable bits
`define MASK_PRIMARY_RST 10'h338
`define MASK_PRIMARY_BITS 10'h3b8
`define MASK_SECONDARY_RST 10'h0ee
`define MASK_SECONDARY_BITS 10'h0ff

// Which latched faults stop switching
`define PRIMARY_STOP_BITS 10'h3a8
`define SECONDARY_STOP_BITS 10'h33f

// Secondary status positions
`define ST2_SELF_TEST 9
`define ST2_HOST_IF 6
`define ST2_REF_RANGE 1
`define ST2_NEG_RAIL 0
`define FAULT_MASK_SECONDARY_REF_RANGE 1
`define FAULT_MASK_SECONDARY_NEG_RAIL 0

// Synchroniser depth for pins
`define SYNC_STAGES 3

`endif

// File: verilog/pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  genvar i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Change counts only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          level[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
